// >>> rtl/rcic_pkg.sv
// Purpose: shared constants and types for the reset cause and init control
// Assumes: system clock of 100 MHz
// Notes:   settle counts are in system clock cycles of the selected oscillator
package rcic_pkg;

    // ------------------------------------------------------------
    // oscillator selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RCIC_OSC_FAST    = 2'h0,
        RCIC_OSC_CRYSTAL = 2'h1,
        RCIC_OSC_SLOW    = 2'h2
    } rcic_osc_t;

    // ------------------------------------------------------------
    // wake settling delays, in cycles of the system clock
    // ------------------------------------------------------------
    localparam int unsigned SETTLE_FAST_CYC    = 16;   // 15 to 16, longest taken
    localparam int unsigned SETTLE_CRYSTAL_CYC = 1024;
    localparam int unsigned SETTLE_SLOW_CYC    = 2;    // 1 to 2, longest taken
    localparam int unsigned SETTLE_CNT_W       = 11;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PORT_DIR_RESET = 8'hff;  // all pins input
    localparam logic [4:0]  ANALOG_RESET   = 5'h1f;  // all five channels analog
    localparam logic        FLAG_CLEAR     = 1'b0;
    localparam logic        FLAG_SET       = 1'b1;

    // ------------------------------------------------------------
    // reset causes seen by the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic supply_drop;   // supply-drop reset request
        logic wdt_timeout;   // watchdog overflow
    } rcic_cause_t;

    // ------------------------------------------------------------
    // flags held in the status register
    // ------------------------------------------------------------
    typedef struct packed {
        logic watchdog_timeout_flag;
        logic power_down_flag;
    } rcic_flags_t;

endpackage

// >>> rtl/rcic_settle_timer.sv
// Purpose: counts the wake settling delay after a watchdog wake
// Assumes: load and count are synchronous to i_clk_sys
// Notes:   o_done is a one-cycle pulse when the count expires
module rcic_settle_timer #(
    parameter int unsigned CNT_W = 11
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    // control
    input  wire logic             i_load,
    input  wire logic [CNT_W-1:0] i_count,
    // status
    output logic                  o_busy,
    output logic                  o_done
);

    logic [CNT_W-1:0] remain;

    // a zero-width counter cannot hold any delay
    if (CNT_W < 1) begin : g_bad_width
        $error("rcic_settle_timer: counter width must be at least one");
    end

    // ------------------------------------------------------------
    // down counter
    // ------------------------------------------------------------
    // load wins over a running count
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remain <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_load) begin
            remain <= i_count - CNT_W'(1);
            o_busy <= 1'b1;
            o_done <= 1'b0;
        end else if (o_busy && remain == '0) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
        end else begin
            remain <= o_busy ? remain - CNT_W'(1) : remain;
            o_done <= 1'b0;
        end
    end

endmodule

// >>> rtl/rcic_core.sv
// Purpose: reset cause flags and initial state control after each reset
// Assumes: inputs synchronous to i_clk_sys; i_rst_n is the power-on reset
// Notes:   o_core_run is low while a reset or a wake settle is in progress
//
// Functional notes
// - sleep watchdog wake clears pc, sp only
// - wake settle delay depends on oscillator
// - status keeps timeout and power-down flags
// - power-on clears both flags
// - supply-drop reset keeps both flags
// - running watchdog reset sets timeout flag
// - sleep watchdog wake sets both flags
// - power-on sets program counter zero
// - power-on disables all interrupts
// - power-on clears watchdog, then counts
// - power-on turns all timers off
// - ports inputs, analog pins to converter
// - power-on sets stack pointer top
// - running watchdog reset gives supply-drop reset initial state
module rcic_core #(
    parameter int unsigned PC_W    = 11,
    parameter int unsigned SP_W    = 3,
    parameter int unsigned PORT_W  = 8,
    parameter int unsigned TIMER_N = 3
) (
    // clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    // reset causes and mode
    input  wire rcic_pkg::rcic_cause_t i_cause,
    input  wire logic                 i_low_power,   // sleep or idle mode
    input  wire logic                 i_enter_halt,  // sleep or idle entry
    input  wire logic                 i_clr_wdt,     // clear-watchdog instruction
    input  wire rcic_pkg::rcic_osc_t  i_osc_sel,
    // status flags
    output rcic_pkg::rcic_flags_t     o_flags,
    // initial state controls
    output logic                      o_pc_clear,
    output logic                      o_sp_clear,
    output logic                      o_sp_top,
    output logic                      o_int_disable,
    output logic                      o_wdt_clear,
    output logic                      o_wdt_run,
    output logic [TIMER_N-1:0]        o_timer_off,
    output logic [PORT_W-1:0]         o_port_dir,
    output logic [4:0]                o_analog_sel,
    output logic                      o_full_reset,
    // core control
    output logic                      o_core_run
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (PC_W < 1 || SP_W < 1 || TIMER_N < 1 || PORT_W < 1) begin : g_bad_param
        $error("rcic_core: widths must be at least one");
    end
    // fast and slow settle lengths must be non-zero and the crystal length must fit the settle counter
    if (rcic_pkg::SETTLE_SLOW_CYC < 1 || rcic_pkg::SETTLE_FAST_CYC < 1 ||
        rcic_pkg::SETTLE_CRYSTAL_CYC >= (1 << rcic_pkg::SETTLE_CNT_W)) begin : g_bad_settle
        $error("rcic_core: settle counts do not fit the settle counter");
    end

    // ------------------------------------------------------------
    // cause decode
    // ------------------------------------------------------------
    logic full_evt;
    logic wake_evt;
    logic run_wdt_evt;
    logic settle_busy;
    logic settle_done;
    logic [rcic_pkg::SETTLE_CNT_W-1:0] settle_count;

    assign run_wdt_evt = i_cause.wdt_timeout && !i_low_power;
    assign wake_evt    = i_cause.wdt_timeout && i_low_power;
    // watchdog in run mode acts as a supply-drop reset
    assign full_evt    = i_cause.supply_drop || run_wdt_evt;

    // settle length by oscillator source
    always_comb begin
        case (i_osc_sel)
            rcic_pkg::RCIC_OSC_FAST:    settle_count =
                rcic_pkg::SETTLE_CNT_W'(rcic_pkg::SETTLE_FAST_CYC);
            rcic_pkg::RCIC_OSC_CRYSTAL: settle_count =
                rcic_pkg::SETTLE_CNT_W'(rcic_pkg::SETTLE_CRYSTAL_CYC);
            rcic_pkg::RCIC_OSC_SLOW:    settle_count =
                rcic_pkg::SETTLE_CNT_W'(rcic_pkg::SETTLE_SLOW_CYC);
            default:                    settle_count =
                rcic_pkg::SETTLE_CNT_W'(rcic_pkg::SETTLE_CRYSTAL_CYC);
        endcase
    end

    // ------------------------------------------------------------
    // settle timer
    // ------------------------------------------------------------
    rcic_settle_timer #(
        .CNT_W (rcic_pkg::SETTLE_CNT_W)
    ) u_settle (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_load    (wake_evt && !settle_busy),
        .i_count   (settle_count),
        .o_busy    (settle_busy),
        .o_done    (settle_done)
    );

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // events take priority over the clearing instructions
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flags.watchdog_timeout_flag <= rcic_pkg::FLAG_CLEAR;
            o_flags.power_down_flag       <= rcic_pkg::FLAG_CLEAR;
        end else if (wake_evt) begin
            o_flags.watchdog_timeout_flag <= rcic_pkg::FLAG_SET;
            o_flags.power_down_flag       <= rcic_pkg::FLAG_SET;
        end else if (run_wdt_evt) begin
            o_flags.watchdog_timeout_flag <= rcic_pkg::FLAG_SET;
        end else if (i_cause.supply_drop) begin
            o_flags <= o_flags;
        end else if (i_enter_halt) begin
            o_flags.watchdog_timeout_flag <= rcic_pkg::FLAG_CLEAR;
            o_flags.power_down_flag       <= rcic_pkg::FLAG_SET;
        end else if (i_clr_wdt) begin
            o_flags.watchdog_timeout_flag <= rcic_pkg::FLAG_CLEAR;
            o_flags.power_down_flag       <= rcic_pkg::FLAG_CLEAR;
        end
    end

    // ------------------------------------------------------------
    // full reset initial state
    // ------------------------------------------------------------
    // held during power-on and for one cycle after any full reset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_full_reset  <= 1'b1;
            o_int_disable <= 1'b1;
            o_sp_top      <= 1'b1;
            o_timer_off   <= '1;
            o_port_dir    <= '1;
            o_analog_sel  <= rcic_pkg::ANALOG_RESET;
        end else begin
            o_full_reset  <= full_evt;
            o_int_disable <= full_evt;
            o_sp_top      <= full_evt;
            o_timer_off   <= {TIMER_N{full_evt}};
            o_port_dir    <= full_evt ? PORT_W'(rcic_pkg::PORT_DIR_RESET)
                                      : '0;
            o_analog_sel  <= full_evt ? rcic_pkg::ANALOG_RESET : 5'h00;
        end
    end

    // ------------------------------------------------------------
    // program counter, stack pointer and watchdog control
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pc_clear  <= 1'b1;
            o_sp_clear  <= 1'b0;
            o_wdt_clear <= 1'b1;
            o_wdt_run   <= 1'b0;
        end else begin
            o_pc_clear  <= full_evt || wake_evt;
            o_sp_clear  <= wake_evt;
            o_wdt_clear <= full_evt || i_clr_wdt;
            o_wdt_run   <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // core release
    // ------------------------------------------------------------
    // stalled during any reset and until the settle delay expires
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_run <= 1'b0;
        end else if (full_evt || wake_evt || (settle_busy && !settle_done)) begin
            o_core_run <= 1'b0;
        end else begin
            o_core_run <= 1'b1;
        end
    end

endmodule

// >>> test/rcic_core_props.sv
// Purpose: assertions on reset cause flags and initial state outputs
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   sees only the ports of rcic_core
module rcic_core_props #(
    parameter int unsigned PORT_W  = 8,
    parameter int unsigned TIMER_N = 3
) (
    input wire logic                  i_clk_sys,
    input wire logic                  i_rst_n,
    input wire rcic_pkg::rcic_cause_t i_cause,
    input wire logic                  i_low_power,
    input wire rcic_pkg::rcic_osc_t   i_osc_sel,
    input wire rcic_pkg::rcic_flags_t o_flags,
    input wire logic                  o_pc_clear,
    input wire logic                  o_sp_clear,
    input wire logic                  o_sp_top,
    input wire logic                  o_int_disable,
    input wire logic                  o_wdt_clear,
    input wire logic                  o_wdt_run,
    input wire logic [TIMER_N-1:0]    o_timer_off,
    input wire logic [PORT_W-1:0]     o_port_dir,
    input wire logic [4:0]            o_analog_sel,
    input wire logic                  o_full_reset,
    input wire logic                  o_core_run
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // watchdog wake while in a low power mode
    wire logic wake = i_cause.wdt_timeout && i_low_power;
    wire logic run_wdt = i_cause.wdt_timeout && !i_low_power;
    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    a_wake_flags_set: assert property (wake |=> o_flags == 2'h3)
        else $error("flags not both set after wake");
    a_wake_pc_sp: assert property (wake |=> o_pc_clear && o_sp_clear && !o_full_reset)
        else $error("wake did not clear only pc and sp");
    a_run_wdt_reset: assert property (run_wdt |=>
        o_flags.watchdog_timeout_flag && o_full_reset
        && o_flags.power_down_flag == $past(o_flags.power_down_flag))
        else $error("running watchdog reset wrong");
    a_drop_keeps_flags: assert property (i_cause.supply_drop && !i_cause.wdt_timeout
        |=> $stable(o_flags))
        else $error("supply drop changed flags");
    a_drop_full_init: assert property (i_cause.supply_drop |=>
        o_full_reset && o_int_disable
        && o_wdt_clear && &o_timer_off && &o_port_dir && o_analog_sel == 5'h1f)
        else $error("supply drop init outputs wrong");
    a_reset_stall_core: assert property (o_full_reset |->
        !o_core_run && o_pc_clear && o_sp_top)
        else $error("full reset without stall or pointer init");
    a_wdt_keeps_run: assert property ($past(i_rst_n) |-> o_wdt_run)
        else $error("watchdog not counting after reset");
    a_settle_fast: assert property (wake && i_osc_sel == rcic_pkg::RCIC_OSC_FAST
        && o_core_run |=> !o_core_run [*8] ##1 !o_core_run [*7] ##[1:3] o_core_run)
        else $error("fast settle length wrong");
    a_settle_slow: assert property (wake && i_osc_sel == rcic_pkg::RCIC_OSC_SLOW
        && o_core_run |=> !o_core_run [*2] ##[1:2] o_core_run)
        else $error("slow settle length wrong");
    c_wake: cover property (wake);
    c_run_wdt: cover property (run_wdt);
    c_drop: cover property (i_cause.supply_drop);
endmodule
bind rcic_core rcic_core_props #(.PORT_W(PORT_W), .TIMER_N(TIMER_N)) rcic_core_props_i (
    .i_clk_sys     (i_clk_sys),
    .i_rst_n       (i_rst_n),
    .i_cause       (i_cause),
    .i_low_power   (i_low_power),
    .i_osc_sel     (i_osc_sel),
    .o_flags       (o_flags),
    .o_pc_clear    (o_pc_clear),
    .o_sp_clear    (o_sp_clear),
    .o_sp_top      (o_sp_top),
    .o_int_disable (o_int_disable),
    .o_wdt_clear   (o_wdt_clear),
    .o_wdt_run     (o_wdt_run),
    .o_timer_off   (o_timer_off),
    .o_port_dir    (o_port_dir),
    .o_analog_sel  (o_analog_sel),
    .o_full_reset  (o_full_reset),
    .o_core_run    (o_core_run)
);

// >>> test/tb_top.sv
// Purpose: self-checking bench for rcic_core
// Assumes: 100 MHz clock, reset held 17 cycles
// Notes:   table of reset events, then reset and refused restart cases
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        clr, sd, wdt, lp;
        logic [1:0]  osc, flg;
        logic        full;
        logic [10:0] lo, hi;
    } rcic_row_t;
    logic i_clk_sys = 0, i_rst_n = 0, i_low_power = 0, i_enter_halt = 0, i_clr_wdt = 0;
    rcic_pkg::rcic_cause_t i_cause = '0;
    rcic_pkg::rcic_osc_t   i_osc_sel = rcic_pkg::RCIC_OSC_FAST;
    rcic_pkg::rcic_flags_t o_flags;
    logic o_pc_clear, o_sp_clear, o_sp_top, o_int_disable, o_wdt_clear, o_wdt_run;
    logic o_full_reset, o_core_run;
    logic [2:0] o_timer_off;
    logic [7:0] o_port_dir;
    logic [4:0] o_analog_sel;
    int fail_count = 0, check_count = 0, cycles = 0, cnt;
    // event rows: clr sd wdt lp osc flags full low-range
    rcic_row_t rows [8] = '{
        '{1, 0, 0, 0, 0, 0, 0, 0, 0}, '{0, 1, 0, 0, 0, 0, 1, 1, 2},
        '{0, 0, 1, 0, 0, 2, 1, 1, 2}, '{0, 1, 0, 0, 0, 2, 1, 1, 2},
        '{0, 0, 1, 1, 0, 3, 0, 15, 18}, '{0, 1, 0, 0, 0, 3, 1, 1, 2},
        '{0, 0, 1, 1, 2, 3, 0, 1, 4}, '{0, 0, 1, 1, 1, 3, 0, 1023, 1026}};
    rcic_core rcic_core_i (.*);
    // clock and hang limit
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // count cycles with the core held
    task automatic count_stall();
        cnt = 0;
        while (o_core_run !== 1'b1 && cnt < 2000) begin
            @(posedge i_clk_sys);
            #1;
            cnt++;
        end
    endtask
    // outputs while power-on reset is held
    task automatic por_check();
        #1;
        check(o_flags, 2'h0);
        check({o_pc_clear, o_sp_top, o_int_disable}, 3'h7);
        check({o_wdt_clear, o_wdt_run, o_core_run}, 3'h4);
        check(o_timer_off, 3'h7);
        check({o_port_dir, o_analog_sel}, 13'h1fff);
    endtask
    initial begin
        repeat (16) @(posedge i_clk_sys);
        por_check();
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        check({o_wdt_run, o_core_run, o_pc_clear}, 3'h6);
        foreach (rows[k]) begin
            @(posedge i_clk_sys);
            i_clr_wdt <= rows[k].clr;
            i_cause <= '{rows[k].sd, rows[k].wdt};
            i_low_power <= rows[k].lp;
            i_osc_sel <= rcic_pkg::rcic_osc_t'(rows[k].osc);
            @(posedge i_clk_sys);
            {i_clr_wdt, i_cause, i_low_power} <= '0;
            #1;
            check(o_flags, rows[k].flg);
            check({o_full_reset, o_int_disable, o_sp_top}, {3{rows[k].full}});
            check({o_pc_clear, o_sp_clear},
                  {rows[k].full | (rows[k].wdt & rows[k].lp), rows[k].wdt & rows[k].lp});
            check(o_wdt_clear, rows[k].full | rows[k].clr);
            check({o_port_dir, o_analog_sel}, {13{rows[k].full}});
            check(o_timer_off, {3{rows[k].full}});
            count_stall();
            check(cnt >= rows[k].lo && cnt <= rows[k].hi, 1'b1);
        end
        // second wake while settling must not restart the delay
        @(posedge i_clk_sys);
        i_osc_sel <= rcic_pkg::RCIC_OSC_FAST;
        i_cause <= '{1'b0, 1'b1};
        i_low_power <= 1'b1;
        @(posedge i_clk_sys);
        i_cause <= '0;
        repeat (7) @(posedge i_clk_sys);
        i_cause <= '{1'b0, 1'b1};
        @(posedge i_clk_sys);
        i_cause <= '0;
        i_low_power <= 1'b0;
        #1;
        count_stall();
        check(cnt >= 6 && cnt <= 10, 1'b1);
        // halt entry, then clear instruction, then clear against a watchdog
        @(posedge i_clk_sys);
        i_enter_halt <= 1'b1;
        @(posedge i_clk_sys);
        i_enter_halt <= 1'b0;
        #1;
        check(o_flags, 2'h1);
        @(posedge i_clk_sys);
        i_clr_wdt <= 1'b1;
        @(posedge i_clk_sys);
        i_clr_wdt <= 1'b0;
        #1;
        check(o_flags, 2'h0);
        check(o_wdt_clear, 1'b1);
        @(posedge i_clk_sys);
        i_clr_wdt <= 1'b1;
        i_cause <= '{1'b0, 1'b1};
        @(posedge i_clk_sys);
        i_clr_wdt <= 1'b0;
        i_cause <= '0;
        #1;
        check(o_flags, 2'h2);
        // power-on reset in mid-run with the timeout flag set
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        por_check();
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        check({o_wdt_run, o_core_run, o_pc_clear}, 3'h6);
        check(o_flags, 2'h0);
        repeat (2) @(posedge i_clk_sys);
        end_of_test();
    end
endmodule
